/* dsum_pkg.sv */
/*
 * Shared constants and types for the channel output summation and sync block.
 * Assumes a single 20 MHz clock domain and an AHB-Lite register port.
 */
package dsum_pkg;

    // ==========================================================
    // Widths, path count and FIFO depth
    localparam int DSUM_W = 16;
    localparam int DSUM_SUM_W = 20;
    localparam int DSUM_NPATH = 4;
    localparam int DSUM_FIFO_DEPTH = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] DSUM_OFF_CTRL = 8'h00;
    localparam logic [7:0] DSUM_OFF_SYNC = 8'h04;
    localparam logic [7:0] DSUM_OFF_TRIM = 8'h08;
    localparam logic [7:0] DSUM_OFF_AUTOREG = 8'h0c;
    localparam logic [7:0] DSUM_OFF_STATUS = 8'h10;

    // ==========================================================
    // Field positions
    localparam int DSUM_CTRL_EN_LSB = 0;
    localparam int DSUM_SYNC_SOFT_BIT = 0;
    localparam int DSUM_SYNC_SEL_LSB = 8;
    localparam int DSUM_SEL_W = 4;

    // ==========================================================
    // Reset values
    localparam logic [3:0] DSUM_CTRL_RST = 4'h1;
    localparam logic [3:0] DSUM_TRIM_RST = 4'h0;
    localparam logic [15:0] DSUM_SEL_RST = 16'h0000;
    localparam logic [31:0] DSUM_AUTOREG_RST = 32'h0000_0000;

    // ==========================================================
    // Trim: current = 2*(code - 11) (mA), with no further offset added
    localparam int DSUM_TRIM_MULT = 2;
    localparam int DSUM_TRIM_OFS = 11;

    // Sync source bit positions inside one selector
    typedef enum logic [1:0] {
        DSUM_SRC_AUTO = 2'h0,
        DSUM_SRC_SOFT = 2'h1,
        DSUM_SRC_SYSREF = 2'h2,
        DSUM_SRC_JESD = 2'h3
    } dsum_src_t;

    // AHB-Lite bus phase capture
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } dsum_aph_t;

    // Four path inputs of one sample
    typedef struct packed {
        logic [15:0] own_ab;
        logic [15:0] own_cd;
        logic [15:0] nb_ab;
        logic [15:0] nb_cd;
    } dsum_paths_t;

endpackage

/* dsum_fifo.sv */
/*
 * Holds no logic: the buffering FIFO module dsum_fifo sits beside dsum_top
 * in the top design file, so that one file carries all the logic.
 * Assumes the top design file is compiled alongside the package.
 */

/* dsum_top.sv */
/*
 * Channel output summation with rounding (two-path sums truncate), four-path sync source gathering,
 * full-scale trim code register and an AHB-Lite register slave.
 * Assumes all inputs synchronous to hclk; path samples arrive after the
 * droop-compensation filters.
 */
`timescale 1ns/1ps
module dsum_top
    import dsum_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] own_chan_path_ab,
    input wire logic [15:0] own_chan_path_cd,
    input wire logic [15:0] neighbor_chan_path_ab,
    input wire logic [15:0] neighbor_chan_path_cd,
    input wire logic paths_valid,
    output logic paths_ready,
    output logic [15:0] channel_sum_out,
    output logic channel_sum_valid,
    input wire logic channel_sum_ready,
    input wire logic sysref,
    input wire logic align_done,
    output logic [3:0] path_sync,
    output logic [3:0] full_scale_trim_code,
    output logic signed [6:0] coarse_trim_ma
);

    // ==========================================================
    // Register state
    logic [3:0] ctrl_q;
    logic [15:0] sel_q;
    logic [31:0] autoreg_q;
    logic [3:0] trim_q;
    logic signed [6:0] coarse_q;
    dsum_aph_t aph_q;
    logic aph_vld_q;
    logic [31:0] rdata_d;
    logic auto_pulse_q;
    logic soft_pulse_q;
    logic sysref_q;
    logic sysref_cap_q;
    logic [3:0] path_sync_q;
    logic [3:0] sync_src;
    logic [DSUM_SUM_W-1:0] sum_d;
    logic [2:0] n_add;
    logic [15:0] rnd_d;
    logic fifo_in_ready;
    logic sum_vld_q;
    logic [15:0] sum_q;
    logic [3:0] seen_q;
    logic wr_ph;

    // Byte-address decode used by both read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_ph = aph_vld_q & aph_q.wr;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_q <= '0;
            aph_vld_q <= 1'b0;
        end else if (hready) begin
            aph_q.wr <= hwrite;
            aph_q.addr <= haddr[7:0];
            aph_vld_q <= hsel & htrans[1];
        end
    end

    // Register writes in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= DSUM_CTRL_RST;
            sel_q <= DSUM_SEL_RST;
            trim_q <= DSUM_TRIM_RST;
            // Current follows the trim reset code, so both leave reset consistent
            coarse_q <= 7'(DSUM_TRIM_MULT * (int'(DSUM_TRIM_RST) - DSUM_TRIM_OFS));
            autoreg_q <= DSUM_AUTOREG_RST;
        end else if (wr_ph) begin
            if (hit(aph_q.addr, DSUM_OFF_CTRL)) begin
                ctrl_q <= hwdata[DSUM_CTRL_EN_LSB +: 4];
            end
            if (hit(aph_q.addr, DSUM_OFF_SYNC)) begin
                sel_q <= hwdata[DSUM_SYNC_SEL_LSB +: 16];
            end
            if (hit(aph_q.addr, DSUM_OFF_TRIM)) begin
                trim_q <= hwdata[3:0];
                coarse_q <= 7'(DSUM_TRIM_MULT * (int'(hwdata[3:0]) - DSUM_TRIM_OFS));
            end
            if (hit(aph_q.addr, DSUM_OFF_AUTOREG)) begin
                autoreg_q <= hwdata;
            end
        end
    end

    // One-cycle pulses once a write completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_pulse_q <= 1'b0;
            soft_pulse_q <= 1'b0;
        end else begin
            auto_pulse_q <= wr_ph & hit(aph_q.addr, DSUM_OFF_AUTOREG);
            soft_pulse_q <= wr_ph & hit(aph_q.addr, DSUM_OFF_SYNC) & hwdata[DSUM_SYNC_SOFT_BIT];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(aph_q.addr, DSUM_OFF_CTRL)) begin
            rdata_d[3:0] = ctrl_q;
        end else if (hit(aph_q.addr, DSUM_OFF_SYNC)) begin
            rdata_d[DSUM_SYNC_SEL_LSB +: 16] = sel_q;
        end else if (hit(aph_q.addr, DSUM_OFF_TRIM)) begin
            rdata_d[3:0] = trim_q;
        end else if (hit(aph_q.addr, DSUM_OFF_AUTOREG)) begin
            rdata_d = autoreg_q;
        end else if (hit(aph_q.addr, DSUM_OFF_STATUS)) begin
            rdata_d = {20'h00000, seen_q, 3'h0, sum_vld_q, n_add, fifo_in_ready};
        end
    end
    assign hrdata = rdata_d;

    // ==========================================================
    // Trim code and derived coarse current, in mA
    assign full_scale_trim_code = trim_q;
    // Registered alongside the code so the output comes straight from a flop
    assign coarse_trim_ma = coarse_q;

    // ==========================================================
    // Sync sources: SYSREF captured on the device clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sysref_q <= 1'b0;
            sysref_cap_q <= 1'b0;
        end else begin
            sysref_q <= sysref;
            sysref_cap_q <= sysref & ~sysref_q;
        end
    end

    assign sync_src[DSUM_SRC_AUTO] = auto_pulse_q;
    assign sync_src[DSUM_SRC_SOFT] = soft_pulse_q;
    assign sync_src[DSUM_SRC_SYSREF] = sysref_cap_q;
    assign sync_src[DSUM_SRC_JESD] = align_done;

    // Identical selector per path; unselected sources ignored
    generate
        for (genvar p = 0; p < DSUM_NPATH; p++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    path_sync_q[p] <= 1'b0;
                end else begin
                    path_sync_q[p] <= |(sync_src & sel_q[p*DSUM_SEL_W +: DSUM_SEL_W]);
                end
            end
        end
    endgenerate
    assign path_sync = path_sync_q;

    // Sticky record of sync events seen, per source; set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 4'h0;
        end else if (aph_vld_q & ~aph_q.wr & hit(aph_q.addr, DSUM_OFF_STATUS)) begin
            seen_q <= sync_src;
        end else begin
            seen_q <= seen_q | sync_src;
        end
    end

    // ==========================================================
    // Summation; ctrl bits enable own AB, own CD, neighbour AB, neighbour CD
    always_comb begin
        sum_d = '0;
        n_add = 3'h0;
        if (ctrl_q[0]) begin
            sum_d = sum_d + DSUM_SUM_W'(signed'(own_chan_path_ab));
            n_add = n_add + 3'h1;
        end
        if (ctrl_q[1]) begin
            sum_d = sum_d + DSUM_SUM_W'(signed'(own_chan_path_cd));
            n_add = n_add + 3'h1;
        end
        if (ctrl_q[2]) begin
            sum_d = sum_d + DSUM_SUM_W'(signed'(neighbor_chan_path_ab));
            n_add = n_add + 3'h1;
        end
        if (ctrl_q[3]) begin
            sum_d = sum_d + DSUM_SUM_W'(signed'(neighbor_chan_path_cd));
            n_add = n_add + 3'h1;
        end
    end

    // Round to 16 bits, truncating with two paths; only the bit just below the window drives the rounding
    always_comb begin
        case (n_add)
            3'h0: rnd_d = sum_d[15:0];
            3'h1: rnd_d = sum_d[16:1] + 16'(sum_d[0]);
            // Two paths: bit zero is simply dropped, no rounding
            3'h2: rnd_d = sum_d[16:1];
            3'h3: rnd_d = sum_d[18:3] + 16'(sum_d[2]);
            3'h4: rnd_d = sum_d[19:4] + 16'(sum_d[3]);
            default: rnd_d = sum_d[15:0];
        endcase
    end

    // Output register feeding the FIFO; stalls while the FIFO is full
    assign paths_ready = ~sum_vld_q | fifo_in_ready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum_vld_q <= 1'b0;
            sum_q <= 16'h0000;
        end else if (paths_ready) begin
            sum_vld_q <= paths_valid;
            sum_q <= rnd_d;
        end
    end

    dsum_fifo #(
        .WIDTH(DSUM_W),
        .DEPTH(DSUM_FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_data(sum_q),
        .in_valid(sum_vld_q),
        .in_ready(fifo_in_ready),
        .out_data(channel_sum_out),
        .out_valid(channel_sum_valid),
        .out_ready(channel_sum_ready)
    );

endmodule

// ==========================================================
// Buffering FIFO: valid/ready on both sides, one clock
module dsum_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshake; the count is one bit wider so full and empty differ
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rp_q];

    // Storage, no reset needed for data words
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* dsum_sva.sv */
/*
 * Port checker for the channel summation and sync block.
 * Assumes it is bound to dsum_top and that everything runs on hclk.
 */
`timescale 1ns/1ps
module dsum_sva
    import dsum_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic paths_valid,
    input wire logic paths_ready,
    input wire logic [15:0] channel_sum_out,
    input wire logic channel_sum_valid,
    input wire logic channel_sum_ready,
    input wire logic sysref,
    input wire logic align_done,
    input wire logic [3:0] path_sync,
    input wire logic [3:0] full_scale_trim_code,
    input wire logic signed [6:0] coarse_trim_ma
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Helper: write data phase and recent sync causes
    logic wr_q;
    logic [7:0] adr_q;
    logic sys_q;
    logic [2:0] cause_q;
    // Three cycles of history cover the slowest source path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            sys_q <= 1'b0;
            cause_q <= 3'h0;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            adr_q <= haddr[7:0];
            sys_q <= sysref;
            cause_q <= {cause_q[1:0], align_done | (sysref & ~sys_q) | wr_q};
        end
    end

    // ==========================================================
    // Properties
    a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
    a_bus_okay: assert property (!hresp) else $error("hresp not OKAY");
    a_trim_current: assert property (coarse_trim_ma == 7'(2 * full_scale_trim_code - 22))
        else $error("coarse trim current wrong");
    a_trim_write: assert property ($changed(full_scale_trim_code) |-> $past(wr_q && adr_q == DSUM_OFF_TRIM))
        else $error("trim code changed without write");
    a_sync_cause: assert property (path_sync != 4'h0 |-> cause_q != 3'h0)
        else $error("path sync without source");
    a_sum_hold: assert property (channel_sum_valid && !channel_sum_ready |=> channel_sum_valid && $stable(channel_sum_out))
        else $error("sum output dropped while stalled");
    a_sum_latency: assert property (paths_valid && paths_ready |-> ##[1:3] channel_sum_valid)
        else $error("sum did not appear");
    a_reset_state: assert property ($rose(hresetn) |-> full_scale_trim_code == 4'h0 && path_sync == 4'h0 && !channel_sum_valid)
        else $error("bad state after reset");

    cover property (paths_valid && !paths_ready);
    cover property (path_sync == 4'hf);
    cover property (channel_sum_valid && channel_sum_ready);
endmodule

/* dsum_link_model.sv */
/*
 * Far side model: SYSREF source and link alignment-done pulse.
 * Assumes the bench fires each event with a one-cycle request.
 */
`timescale 1ns/1ps
module dsum_link_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire_sysref,
    input wire logic fire_align,
    output logic sysref,
    output logic align_done
);
    logic [2:0] hold_q;
    // SYSREF held four cycles so capture never misses it; align is one pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 3'h0;
            sysref <= 1'b0;
            align_done <= 1'b0;
        end else begin
            hold_q <= fire_sysref ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
            sysref <= fire_sysref || hold_q > 3'h1;
            align_done <= fire_align;
        end
    end
endmodule

/* duc_output_sum_and_sync_tb.sv */
/*
 * Self-checking bench for the summation and sync block.
 * Assumes dsum_top, dsum_fifo, dsum_link_model and dsum_sva are compiled.
 */
`timescale 1ns/1ps
module duc_output_sum_and_sync_tb;
    import dsum_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, paths_valid, paths_ready;
    logic channel_sum_valid, channel_sum_ready, sysref, align_done, fire_sysref, fire_align;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] own_chan_path_ab, own_chan_path_cd, neighbor_chan_path_ab, neighbor_chan_path_cd, channel_sum_out;
    logic [3:0] path_sync, full_scale_trim_code;
    logic signed [6:0] coarse_trim_ma;
    int err_total, n_tests, cyc;

    dsum_top dsum_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .own_chan_path_ab, .own_chan_path_cd, .neighbor_chan_path_ab,
        .neighbor_chan_path_cd, .paths_valid, .paths_ready, .channel_sum_out, .channel_sum_valid,
        .channel_sum_ready, .sysref, .align_done, .path_sync, .full_scale_trim_code, .coarse_trim_ma);
    dsum_link_model dsum_link_model_inst (.hclk, .hresetn, .fire_sysref, .fire_align, .sysref, .align_done);

    // ==========================================================
    // Clock and hang guard
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single AHB transfer; zero-wait slave, but the wait is not assumed
    task automatic ahb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Rounded sum; two paths drop bit zero without rounding
    function automatic logic [15:0] esum(logic [3:0] en, logic [63:0] p);
        logic signed [19:0] s;
        int k, sh;
        s = 0;
        k = 0;
        for (int j = 0; j < 4; j++) if (en[j]) begin
            s += $signed(p[63 - 16 * j -: 16]);
            k++;
        end
        sh = (k == 2) ? 1 : k;
        if (k != 2 && sh > 0) s += 20'(1 << (sh - 1));
        return 16'(s >>> sh);
    endfunction

    // ==========================================================
    // Scenarios
    task automatic run_regs();
        ahb(0, DSUM_OFF_CTRL, 32'h0, rd);
        check("ctrl reset", rd, 32'(DSUM_CTRL_RST));
        ahb(1, 8'h20, 32'hffff_ffff, rd);
        ahb(0, 8'h20, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        ahb(1, DSUM_OFF_AUTOREG, 32'h5a5a_c3c3, rd);
        ahb(0, DSUM_OFF_AUTOREG, 32'h0, rd);
        check("auto reg", rd, 32'h5a5a_c3c3);
        ahb(1, DSUM_OFF_SYNC, 32'h00ab_cd01, rd);
        ahb(0, DSUM_OFF_SYNC, 32'h0, rd);
        check("sync sel", rd, 32'h00ab_cd00);
        ahb(1, DSUM_OFF_SYNC, 32'h0, rd);
        // Auto and soft sources seen since reset; the read clears them
        ahb(0, DSUM_OFF_STATUS, 32'h0, rd);
        check("status", rd, 32'h0000_0303);
        ahb(0, DSUM_OFF_STATUS, 32'h0, rd);
        check("status clr", rd, 32'h0000_0003);
        for (int c = 0; c < 16; c++) begin
            ahb(1, DSUM_OFF_TRIM, 32'(c), rd);
            @(negedge hclk);
            check("trim code", 32'(full_scale_trim_code), 32'(c));
            check("coarse", 32'(coarse_trim_ma), 32'(2 * c - 22));
            @(posedge hclk);
            ahb(0, DSUM_OFF_TRIM, 32'h0, rd);
            check("trim read", rd, 32'(c));
        end
    endtask

    // Fill until refused with the sink stalled, then drain and compare
    task automatic run_sum(logic [3:0] en);
        logic [15:0] q[$];
        logic [63:0] p;
        int i;
        ahb(1, DSUM_OFF_CTRL, {28'h0, en}, rd);
        i = 0;
        forever begin
            p = {16'h1235 + 16'(i * 257), 16'h0ffb, 16'h8003 - 16'(i), 16'h7fff};
            {own_chan_path_ab, own_chan_path_cd, neighbor_chan_path_ab, neighbor_chan_path_cd} <= p;
            paths_valid <= 1'b1;
            @(negedge hclk);
            if (paths_ready !== 1'b1) break;
            q.push_back(esum(en, p));
            i++;
            @(posedge hclk);
        end
        // Refused sample is withdrawn at the edge, so it is never taken
        @(posedge hclk);
        paths_valid <= 1'b0;
        channel_sum_ready <= 1'b1;
        check("fill depth", 32'(i), 32'(DSUM_FIFO_DEPTH + 1));
        while (q.size() > 0) begin
            @(negedge hclk);
            if (channel_sum_valid === 1'b1) check("sum", 32'(channel_sum_out), 32'(q.pop_front()));
            @(posedge hclk);
        end
        channel_sum_ready <= 1'b0;
        @(negedge hclk);
        check("drained", 32'(channel_sum_valid), 32'h0);
        @(posedge hclk);
    endtask

    // Program selectors, raise chosen sources, gather path pulses
    task automatic run_sync(logic [31:0] sel, logic [3:0] ev, logic [3:0] exp);
        logic [3:0] acc;
        ahb(1, DSUM_OFF_SYNC, sel, rd);
        if (ev[0]) ahb(1, DSUM_OFF_AUTOREG, 32'h1, rd);
        if (ev[1]) ahb(1, DSUM_OFF_SYNC, sel | 32'h1, rd);
        fire_sysref <= ev[2];
        fire_align <= ev[3];
        // Requests stand one full cycle so the model samples them
        @(posedge hclk);
        fire_sysref <= 1'b0;
        fire_align <= 1'b0;
        acc = 4'h0;
        repeat (8) begin
            @(negedge hclk);
            acc |= path_sync;
        end
        @(posedge hclk);
        check("path sync", 32'(acc), 32'(exp));
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        hclk = 1'b0;
        hsize = 3'h2;
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, paths_valid, channel_sum_ready, fire_sysref, fire_align} = '0;
        {own_chan_path_ab, own_chan_path_cd, neighbor_chan_path_ab, neighbor_chan_path_cd} = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        run_regs();
        run_sum(4'h1);
        run_sum(4'h3);
        run_sum(4'h7);
        run_sum(4'hf);
        run_sum(4'h5);
        run_sum(4'ha);
        run_sum(4'h0);
        run_sync(32'h0084_2100, 4'h1, 4'h1);
        run_sync(32'h0084_2100, 4'h2, 4'h2);
        run_sync(32'h0084_2100, 4'h4, 4'h4);
        run_sync(32'h0084_2100, 4'h8, 4'h8);
        run_sync(32'h00ff_ff00, 4'h8, 4'hf);
        run_sync(32'h0000_0000, 4'hf, 4'h0);
        finish_test();
    end
endmodule

bind dsum_top dsum_sva dsum_sva_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .paths_valid, .paths_ready, .channel_sum_out, .channel_sum_valid, .channel_sum_ready, .sysref, .align_done,
    .path_sync, .full_scale_trim_code, .coarse_trim_ma);
